// ---- core/pix_out_defs.svh ----
`ifndef PIX_OUT_DEFS_SVH
`define PIX_OUT_DEFS_SVH

// pixel and buffer geometry
`define PIX_WIDTH 24
`define PIX_FIFO_DEPTH 8
`define PIX_LINE_CNT_W 12
`define PIX_LINE_TOTAL_DEFAULT 12'h320

// recovered line sync stays active for this many pixel clocks
`define PIX_SYNC_ACTIVE_CYCLES 3'h4

// pixel clock rate and the hsync to reference delay
`define PIX_CLK_PERIOD_NS 10
`define PIX_REF_DELAY_NS 7
`define PIX_REF_DELAY_CYCLES \
  (((`PIX_REF_DELAY_NS + `PIX_CLK_PERIOD_NS - 1) / `PIX_CLK_PERIOD_NS) < 1 ? 1 : \
   ((`PIX_REF_DELAY_NS + `PIX_CLK_PERIOD_NS - 1) / `PIX_CLK_PERIOD_NS))

// reset values
`define PIX_OCLK_RESET 1'b1

`endif

// ---- core/pix_out_pkg.sv ----
package pix_out_pkg;

  // which half of a two-pixel pair the packer waits for
  typedef enum logic {
    PK_FIRST,
    PK_SECOND
  } pack_state_t;

endpackage : pix_out_pkg

// ---- core/pixel_fifo.sv ----
`timescale 1ns/1ps
`include "pix_out_defs.svh"

module pixel_fifo #(
  parameter int WIDTH = `PIX_WIDTH,
  parameter int DEPTH = `PIX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic ready_r;

  wire push = i_in_valid & ready_r;
  wire pop = o_out_valid & i_out_ready;
  wire wr_last = (wr_ptr_r == AW'(DEPTH - 1));
  wire rd_last = (rd_ptr_r == AW'(DEPTH - 1));

  assign o_in_ready = ready_r;
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data = mem[rd_ptr_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= i_in_data;
    end
  end

  // ready is registered so a full buffer stalls the source cleanly
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_last ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_last ? '0 : rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      ready_r <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end

endmodule : pixel_fifo

// ---- core/pixel_output_mode_select.sv ----
// Summary of operation
// - line reference pulse follows each hsync rising edge
// - phase detector compares reference with recovered sync
// - packing bit zero: two pixels on A and B
// - packing bit one: one pixel, A only
// - assign bit zero: A carries falling-edge samples
// - assign bit one: B carries falling-edge samples
// - packing bit zero: A and B presented together on rising edge
// - one-pixel mode holds all B outputs at zero
`timescale 1ns/1ps
`include "pix_out_defs.svh"

module pixel_output_mode_select #(
  parameter int PIX_W = `PIX_WIDTH,
  parameter int FIFO_DEPTH = `PIX_FIFO_DEPTH,
  parameter int LINE_W = `PIX_LINE_CNT_W
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // sync pin and line length
  input wire logic i_hsync,
  input wire logic [LINE_W-1:0] i_line_total,
  // mode control
  input wire logic i_one_pixel_mode,
  input wire logic i_chan_assign,
  // captured pixels in
  input wire logic i_pix_valid,
  output logic o_pix_ready,
  input wire logic [PIX_W-1:0] i_pix_data,
  // display controller side
  input wire logic i_out_ready,
  output logic o_pixel_output_clock,
  output logic o_out_valid,
  output logic [PIX_W-1:0] o_chan_a,
  output logic [PIX_W-1:0] o_chan_b,
  // line lock loop
  output logic o_line_ref,
  output logic o_recovered_line_sync,
  output logic o_phase_up,
  output logic o_phase_down
);

  localparam int REF_DLY = `PIX_REF_DELAY_CYCLES;

  ////////////////////////////////////////////////////////////////////////////////
  // hsync capture and line reference

  logic hs_meta_r;
  logic hs_sync_r;
  logic hs_prev_r;
  logic [REF_DLY-1:0] ref_pipe_r;

  wire hs_rise = hs_sync_r & ~hs_prev_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      hs_meta_r <= 1'b0;
      hs_sync_r <= 1'b0;
      hs_prev_r <= 1'b0;
    end else begin
      hs_meta_r <= i_hsync;
      hs_sync_r <= hs_meta_r;
      hs_prev_r <= hs_sync_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ref_pipe_r <= '0;
    end else if (REF_DLY == 1) begin
      ref_pipe_r <= REF_DLY'(hs_rise);
    end else begin
      ref_pipe_r <= REF_DLY'({ref_pipe_r, hs_rise});
    end
  end

  wire ref_evt = ref_pipe_r[REF_DLY-1];

  ////////////////////////////////////////////////////////////////////////////////
  // divider chain, output clock and recovered sync

  logic [LINE_W-1:0] line_cnt_r;
  logic [2:0] sync_left_r;
  logic sync_r;
  logic oclk_r;

  // a line total of zero would never wrap cleanly, so it behaves as one
  wire [LINE_W-1:0] line_last = (i_line_total == '0) ? '0 : i_line_total - LINE_W'(1);
  wire line_wrap = (line_cnt_r >= line_last);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      line_cnt_r <= '0;
    end else begin
      line_cnt_r <= line_wrap ? '0 : line_cnt_r + LINE_W'(1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      oclk_r <= `PIX_OCLK_RESET;
    end else if (i_one_pixel_mode) begin
      oclk_r <= 1'b1;
    end else if (line_wrap) begin
      oclk_r <= 1'b0;
    end else begin
      oclk_r <= ~oclk_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sync_left_r <= '0;
      sync_r <= 1'b0;
    end else if (line_wrap) begin
      sync_left_r <= `PIX_SYNC_ACTIVE_CYCLES - 3'h1;
      sync_r <= 1'b1;
    end else if (sync_left_r != '0) begin
      sync_left_r <= sync_left_r - 3'h1;
      sync_r <= 1'b1;
    end else begin
      sync_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // phase frequency detector

  logic up_r;
  logic down_r;

  wire up_set = up_r | ref_evt;
  wire down_set = down_r | line_wrap;
  wire pfd_clear = up_set & down_set;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      up_r <= 1'b0;
      down_r <= 1'b0;
    end else begin
      up_r <= up_set & ~pfd_clear;
      down_r <= down_set & ~pfd_clear;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pixel buffer

  logic fifo_valid;
  logic [PIX_W-1:0] fifo_data;
  logic fifo_pop;

  pixel_fifo #(
    .WIDTH(PIX_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_in_valid(i_pix_valid),
    .o_in_ready(o_pix_ready),
    .i_in_data(i_pix_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // packer

  pix_out_pkg::pack_state_t pk_r;
  logic [PIX_W-1:0] hold_r;
  logic [PIX_W-1:0] a_r;
  logic [PIX_W-1:0] b_r;
  logic valid_r;

  // first of a pair is taken before the falling edge, second before the rising one
  // a wrap forces the clock low, so a pair finished there would miss the rising edge
  wire pair_slot = (pk_r == pix_out_pkg::PK_FIRST) ? oclk_r : (~oclk_r & ~line_wrap);
  assign fifo_pop = fifo_valid & i_out_ready & (i_one_pixel_mode | pair_slot);
  wire pair_done = fifo_pop & ~i_one_pixel_mode & (pk_r == pix_out_pkg::PK_SECOND);
  wire [PIX_W-1:0] pair_a = i_chan_assign ? fifo_data : hold_r;
  wire [PIX_W-1:0] pair_b = i_chan_assign ? hold_r : fifo_data;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset || i_one_pixel_mode) begin
      pk_r <= pix_out_pkg::PK_FIRST;
    end else if (fifo_pop) begin
      unique case (pk_r)
        pix_out_pkg::PK_FIRST: pk_r <= pix_out_pkg::PK_SECOND;
        pix_out_pkg::PK_SECOND: pk_r <= pix_out_pkg::PK_FIRST;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      hold_r <= '0;
    end else if (fifo_pop && pk_r == pix_out_pkg::PK_FIRST) begin
      hold_r <= fifo_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      a_r <= '0;
      b_r <= '0;
      valid_r <= 1'b0;
    end else if (i_one_pixel_mode) begin
      valid_r <= fifo_pop;
      if (fifo_pop) begin
        a_r <= fifo_data;
      end
      b_r <= '0;
    end else begin
      valid_r <= pair_done;
      if (pair_done) begin
        a_r <= pair_a;
        b_r <= pair_b;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_line_ref = ref_pipe_r[REF_DLY-1];
  assign o_recovered_line_sync = sync_r;
  assign o_phase_up = up_r;
  assign o_phase_down = down_r;
  assign o_pixel_output_clock = oclk_r;
  assign o_out_valid = valid_r;
  assign o_chan_a = a_r;
  assign o_chan_b = b_r;

endmodule : pixel_output_mode_select

// ---- dv/pixel_output_mode_select_properties.sv ----
`timescale 1ns/1ps
module pixel_output_mode_select_properties #(
  parameter int PIX_W = 24
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_hsync,
  input wire logic i_one_pixel_mode,
  input wire logic i_out_ready,
  input wire logic o_pixel_output_clock,
  input wire logic o_out_valid,
  input wire logic [PIX_W-1:0] o_chan_b,
  input wire logic o_line_ref,
  input wire logic o_recovered_line_sync,
  input wire logic o_phase_up,
  input wire logic o_phase_down
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_sync_hold;
    o_recovered_line_sync [*4] ##1 !o_recovered_line_sync;
  endsequence
  sequence s_pair_edge;
    o_pixel_output_clock && !$past(o_pixel_output_clock);
  endsequence
  ////////////////////////////////////////////////////////////
  a_b_held_zero: assert property (i_one_pixel_mode |=> o_chan_b == '0)
    else $error("chan b not zero");
  a_oclk_high: assert property (i_one_pixel_mode |=> o_pixel_output_clock)
    else $error("output clock not held");
  a_oclk_toggle: assert property (!$past(i_one_pixel_mode) && !$rose(o_recovered_line_sync)
    |-> o_pixel_output_clock != $past(o_pixel_output_clock)) else $error("no toggle");
  a_pair_rise: assert property (o_out_valid && !$past(i_one_pixel_mode) |-> s_pair_edge)
    else $error("pair off rising edge");
  a_pair_gap: assert property (o_out_valid && !$past(i_one_pixel_mode) |=> !o_out_valid)
    else $error("pairs too close");
  a_one_ready: assert property (o_out_valid && $past(i_one_pixel_mode)
    |-> $past(i_out_ready) || $past(i_out_ready, 2)) else $error("word without ready");
  a_sync_four: assert property ($rose(o_recovered_line_sync) |-> s_sync_hold)
    else $error("sync width wrong");
  a_ref_follow: assert property ($rose(i_hsync) |-> ##[3:6] o_line_ref)
    else $error("no reference pulse");
  a_ref_pulse: assert property (o_line_ref |=> !o_line_ref)
    else $error("reference too long");
  a_up_cause: assert property ($rose(o_phase_up) |-> $past(o_line_ref))
    else $error("up without reference");
  a_down_cause: assert property ($rose(o_phase_down) |-> o_recovered_line_sync)
    else $error("down without sync");
  a_pfd_excl: assert property (!(o_phase_up && o_phase_down))
    else $error("up and down together");
endmodule : pixel_output_mode_select_properties

bind pixel_output_mode_select pixel_output_mode_select_properties #(.PIX_W(PIX_W)) i_props (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_hsync(i_hsync),
  .i_one_pixel_mode(i_one_pixel_mode), .i_out_ready(i_out_ready),
  .o_pixel_output_clock(o_pixel_output_clock), .o_out_valid(o_out_valid),
  .o_chan_b(o_chan_b), .o_line_ref(o_line_ref),
  .o_recovered_line_sync(o_recovered_line_sync),
  .o_phase_up(o_phase_up), .o_phase_down(o_phase_down));

// ---- dv/display_sink.sv ----
`timescale 1ns/1ps
module display_sink #(
  parameter int W = 24
) (
  input wire logic i_ref_clk,
  input wire logic i_slow,
  input wire logic i_hold,
  input wire logic i_valid,
  input wire logic [W-1:0] i_a,
  input wire logic [W-1:0] i_b,
  output logic o_ready
);
  logic [2*W-1:0] q[$];
  logic [1:0] ph = 2'h0;
  initial o_ready = 1'b0;
  // slow mode accepts two cycles in four, so both clock phases see ready
  always @(negedge i_ref_clk) begin
    ph <= ph + 2'h1;
    o_ready <= !i_hold && (i_slow ? ph[1] : 1'b1);
    if (i_valid === 1'b1)
      q.push_back({i_a, i_b});
  end
endmodule : display_sink

// ---- dv/pixel_output_mode_select_tb.sv ----
`timescale 1ns/1ps
module pixel_output_mode_select_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsync = 1'b0;
  logic one_pix = 1'b1;
  logic asg = 1'b0;
  logic pix_valid = 1'b0;
  logic [23:0] pix_data = 24'h000000;
  logic hold = 1'b0;
  logic slow = 1'b0;
  logic pix_ready, out_ready, oclk, out_valid, line_ref, rsync, up, dn;
  logic [23:0] chan_a, chan_b;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  pixel_output_mode_select i_dut (.i_ref_clk(clk), .i_reset(reset), .i_hsync(hsync),
    .i_line_total(12'h014), .i_one_pixel_mode(one_pix), .i_chan_assign(asg),
    .i_pix_valid(pix_valid), .o_pix_ready(pix_ready), .i_pix_data(pix_data),
    .i_out_ready(out_ready), .o_pixel_output_clock(oclk), .o_out_valid(out_valid),
    .o_chan_a(chan_a), .o_chan_b(chan_b), .o_line_ref(line_ref),
    .o_recovered_line_sync(rsync), .o_phase_up(up), .o_phase_down(dn));
  display_sink i_sink (.i_ref_clk(clk), .i_slow(slow), .i_hold(hold), .i_valid(out_valid),
    .i_a(chan_a), .i_b(chan_b), .o_ready(out_ready));
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // valid stays up between words so the strobe is never assigned twice in a step
  task push(input logic [23:0] w);
    pix_valid = 1'b1;
    pix_data = w;
    while (pix_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
  endtask : push
  task drain(input int n);
    pix_valid = 1'b0;
    repeat (300) if (i_sink.q.size() < n) @(negedge clk);
  endtask : drain
  ////////////////////////////////////////////////////////////
  task t_fill;
    one_pix = 1'b1;
    hold = 1'b1;
    i_sink.q.delete();
    for (int i = 0; i < 8; i++) push(24'h000100 + 24'(i));
    drain(0);
    repeat (2) @(negedge clk);
    chk(24'(pix_ready), 24'h000000);
    hold = 1'b0;
    drain(8);
    chk(24'(i_sink.q.size()), 24'h000008);
    for (int i = 0; i < 8; i++) begin
      chk(i_sink.q[i][47:24], 24'h000100 + 24'(i));
      chk(i_sink.q[i][23:0], 24'h000000);
    end
    chk(24'(oclk), 24'h000001);
    $display("t_fill done");
  endtask : t_fill
  task t_two(input logic a);
    one_pix = 1'b0;
    asg = a;
    slow = 1'b1;
    i_sink.q.delete();
    for (int i = 0; i < 8; i++) push(24'h000200 + 24'(i));
    drain(4);
    chk(24'(i_sink.q.size()), 24'h000004);
    for (int j = 0; j < 4; j++) begin
      chk(i_sink.q[j][47:24], 24'h000200 + 24'(2 * j + int'(a)));
      chk(i_sink.q[j][23:0], 24'h000200 + 24'(2 * j + 1 - int'(a)));
    end
    slow = 1'b0;
    $display("t_two done");
  endtask : t_two
  task t_line;
    int k;
    int hi;
    chk(24'({up, dn}), 24'h000001);
    hsync = 1'b1;
    k = 0;
    while (line_ref !== 1'b1 && k < 8) begin
      @(negedge clk);
      k++;
    end
    chk(24'(line_ref), 24'h000001);
    @(negedge clk);
    chk(24'({up, dn}), 24'h000000);
    hsync = 1'b0;
    k = 0;
    while (rsync !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    hi = 0;
    while (rsync === 1'b1 && hi < 10) begin
      @(negedge clk);
      hi++;
    end
    chk(24'(hi), 24'h000004);
    while (rsync !== 1'b1 && hi < 40) begin
      @(negedge clk);
      hi++;
    end
    chk(24'(hi), 24'h000014);
    $display("t_line done");
  endtask : t_line
  ////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    t_fill();
    t_two(1'b0);
    t_two(1'b1);
    t_line();
    finish_test();
  end
endmodule : pixel_output_mode_select_tb
